// ===== hw/dof_pkg.sv
// constants and types of the two-channel output formatter
// assumes one 10 MHz clock and a plain word-wide register port
package dof_pkg;

  // ==========================================================================
  // register port
  localparam int         ADDR_W        = 4;
  localparam logic [3:0] OFS_CTRL      = 4'h0;
  localparam logic [3:0] OFS_RATE      = 4'h4;
  localparam logic [3:0] OFS_STATUS    = 4'h8;

  // control word fields
  localparam int         CTRL_SER_EN   = 0;
  localparam int         CTRL_CLK_POL  = 1;
  localparam int         CTRL_STB_POL  = 2;
  localparam int         CTRL_MUX      = 3;
  localparam int         CTRL_PACKED   = 4;
  localparam int         CTRL_FMT_LSB  = 5;
  localparam logic [7:0] CTRL_RESET    = 8'h00;

  // status word fields
  localparam int         STAT_BUSY     = 0;
  localparam int         STAT_OVERRUN  = 1;
  localparam int         STAT_SEL_LSB  = 2;
  localparam int         STAT_OE       = 5;

  // serial rate divider: bit period = rate + 1 clocks
  localparam logic [7:0] RATE_RESET    = 8'h01;

  // ==========================================================================
  // number formats
  typedef enum logic [2:0] {
    FMT_TRUNC8  = 3'b000,
    FMT_ROUND16 = 3'b001,
    FMT_ROUND24 = 3'b010,
    FMT_TRUNC32 = 3'b011,
    FMT_FLOAT12 = 3'b100
  } dof_fmt_t;

  localparam int         SAMPLE_W      = 32;
  localparam int         SEG_W         = 16;
  localparam int         MANT_W        = 8;
  localparam int         EXP_W         = 4;
  localparam logic [6:0] LEN_FLOAT     = 7'h18;  // mI eI eQ mQ, 24 bits
  localparam logic [32:0] HALF_LSB16   = 33'h0_0000_8000;
  localparam logic [32:0] HALF_LSB24   = 33'h0_0000_0080;
  localparam logic [31:0] MAX_POS      = 32'h7FFF_FFFF;
  localparam logic [31:0] MAX_NEG      = 32'h8000_0000;

  // ==========================================================================
  // serial engine states
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } dof_state_t;

endpackage : dof_pkg

// ===== hw/dof_output_formatter.sv
// output formatting stage: holding registers, serial framer, parallel port
// assumes sample strobe and words come from logic on clk; select and
// enable pins are asynchronous and resynchronised here
module dof_output_formatter (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  // decimated samples, same clock
  input  wire logic                       sampleValid,
  input  wire logic [31:0]                sampleIA,
  input  wire logic [31:0]                sampleQA,
  input  wire logic [31:0]                sampleIB,
  input  wire logic [31:0]                sampleQB,
  // register port
  input  wire logic [dof_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [31:0]                regWrData,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [31:0]                regRdData,
  // pins from the far side
  input  wire logic [2:0]                 segmentSelect,
  input  wire logic                       parallelOutputEnable_n,
  // pins to the far side
  output logic                            sampleReady,
  output logic                            serialClock,
  output logic                            serialClockOe,
  output logic                            serialFrameStrobe,
  output logic                            serialFrameStrobeOe,
  output logic                            serialDataLineA,
  output logic                            serialDataLineAOe,
  output logic                            serialDataLineB,
  output logic                            serialDataLineBOe,
  output logic      [15:0]                parallelData,
  output logic                            parallelOe
);

  // ==========================================================================
  // state
  typedef struct packed {
    dof_pkg::dof_state_t st;
    logic [7:0]          ctrl;
    logic [7:0]          rate;
    logic                overrun;
    logic [7:0]          divCnt;
    logic [7:0]          bitsLeft;
    logic [7:0]          total;
    logic [6:0]          wordLen;
    logic [6:0]          wordLeft;
    logic                clkPol;
    logic                stbPol;
    logic                muxOne;
    logic [127:0]        shA;
    logic [127:0]        shB;
    logic [3:0][31:0]    hold;       // IA, QA, IB, QB parallel words
    logic [2:0]          selS1;
    logic [2:0]          selS2;
    logic [2:0]          selS3;
    logic [2:0]          selStable;
    logic                enS1;
    logic                enS2;
    logic                enS3;
    logic                enStable_n;
    logic [31:0]         rdData;
    logic                ready;
    logic                sck;
    logic                sckOe;
    logic                fs;
    logic                dA;
    logic                dB;
    logic [15:0]         pData;
    logic                pOe;
  } dof_regs_t;

  dof_regs_t r;
  dof_regs_t next_r;

  // ==========================================================================
  // number formatting

  // format decode
  // saturating round of the top bits; mask keeps the valid MSBs
  function automatic logic [31:0] roundTop(input logic [31:0] x,
                                           input logic [32:0] half,
                                           input logic [31:0] mask);
    logic [32:0] sum;
    sum = {x[31], x} + half;
    if (sum[32] != sum[31]) begin
      roundTop = x[31] ? dof_pkg::MAX_NEG : (dof_pkg::MAX_POS & mask);
    end else begin
      roundTop = sum[31:0] & mask;
    end
  endfunction : roundTop

  // fixed word, valid bits at the top, rest zero
  function automatic logic [31:0] fixWord(input logic [31:0] x,
                                          input logic [2:0]  fmt);
    case (fmt)
      dof_pkg::FMT_TRUNC8:  fixWord = {x[31:24], 24'h00_0000};
      dof_pkg::FMT_ROUND16: fixWord = roundTop(x, dof_pkg::HALF_LSB16, 32'hFFFF_0000);
      dof_pkg::FMT_ROUND24: fixWord = roundTop(x, dof_pkg::HALF_LSB24, 32'hFFFF_FF00);
      default:              fixWord = x;
    endcase
  endfunction : fixWord

  // float: exponent counts down with each redundant sign bit removed
  function automatic logic [11:0] fltWord(input logic [31:0] x);
    logic [31:0] y;
    logic [3:0]  n;
    logic        go;
    y  = x;
    n  = 4'h0;
    go = 1'b1;
    for (int i = 0; i < 15; i++) begin
      if (go && (y[31] == y[30])) begin
        y = {y[30:0], 1'b0};
        n = n + 4'h1;
      end else begin
        go = 1'b0;
      end
    end
    fltWord = {4'hF - n, y[31:24]};
  endfunction : fltWord

  // bits per component on the serial line
  function automatic logic [6:0] compLen(input logic [2:0] fmt);
    case (fmt)
      dof_pkg::FMT_TRUNC8:  compLen = 7'h08;
      dof_pkg::FMT_ROUND16: compLen = 7'h10;
      dof_pkg::FMT_ROUND24: compLen = 7'h18;
      default:              compLen = 7'h20;
    endcase
  endfunction : compLen

  // ==========================================================================
  // next state
  always_comb begin
    logic [2:0]   fmt;
    logic         isFloat;
    logic [6:0]   cLen;
    logic [3:0][31:0] fixW;
    logic [11:0]  fIA;
    logic [11:0]  fQA;
    logic [11:0]  fIB;
    logic [11:0]  fQB;
    logic [63:0]  strA;
    logic [63:0]  strB;
    logic [7:0]   chanLen;
    logic [8:0]   halfPer;
    logic [31:0]  word;
    next_r  = r;
    fmt     = r.ctrl[dof_pkg::CTRL_FMT_LSB +: 3];
    isFloat = (fmt == dof_pkg::FMT_FLOAT12);
    cLen    = compLen(fmt);
    fIA     = fltWord(sampleIA);
    fQA     = fltWord(sampleQA);
    fIB     = fltWord(sampleIB);
    fQB     = fltWord(sampleQB);
    fixW[0] = fixWord(sampleIA, fmt);
    fixW[1] = fixWord(sampleQA, fmt);
    fixW[2] = fixWord(sampleIB, fmt);
    fixW[3] = fixWord(sampleQB, fmt);
    // I bits then Q bits back to back
    strA    = {fixW[0], 32'h0000_0000} | ({fixW[1], 32'h0000_0000} >> cLen);
    strB    = {fixW[2], 32'h0000_0000} | ({fixW[3], 32'h0000_0000} >> cLen);
    chanLen = {cLen[6:0], 1'b0};
    // rate 0 leaves no high half: the bit clock then rests at idle level
    halfPer = ({1'b0, r.rate} + 9'h001) >> 1;
    word    = 32'h0000_0000;

    // register writes; overrun clears on a written one
    if (regWr) begin
      if (regAddr == dof_pkg::OFS_CTRL) begin
        next_r.ctrl = regWrData[7:0];
      end else if (regAddr == dof_pkg::OFS_RATE) begin
        next_r.rate = regWrData[7:0];
      end else if (regAddr == dof_pkg::OFS_STATUS) begin
        if (regWrData[dof_pkg::STAT_OVERRUN]) begin
          next_r.overrun = 1'b0;
        end
      end
    end

    // register reads, data stands one cycle later; unmapped reads zero
    next_r.rdData = 32'h0000_0000;
    if (regRd) begin
      if (regAddr == dof_pkg::OFS_CTRL) begin
        next_r.rdData = {24'h00_0000, r.ctrl};
      end else if (regAddr == dof_pkg::OFS_RATE) begin
        next_r.rdData = {24'h00_0000, r.rate};
      end else if (regAddr == dof_pkg::OFS_STATUS) begin
        next_r.rdData[dof_pkg::STAT_BUSY]                = (r.st == dof_pkg::ST_SHIFT);
        next_r.rdData[dof_pkg::STAT_OVERRUN]             = r.overrun;
        next_r.rdData[dof_pkg::STAT_SEL_LSB +: 3]        = r.selStable;
        next_r.rdData[dof_pkg::STAT_OE]                  = ~r.enStable_n;
      end
    end

    // serial engine: one bit per rate+1 clocks
    case (r.st)
      dof_pkg::ST_IDLE: begin
        next_r.divCnt = 8'h00;
      end
      dof_pkg::ST_SHIFT: begin
        if (r.divCnt == r.rate) begin
          next_r.divCnt   = 8'h00;
          next_r.shA      = {r.shA[126:0], 1'b0};
          next_r.shB      = {r.shB[126:0], 1'b0};
          next_r.bitsLeft = r.bitsLeft - 8'h01;
          next_r.wordLeft = (r.wordLeft == 7'h01) ? r.wordLen : r.wordLeft - 7'h01;
          // clock rests after the last bit
          if (r.bitsLeft == 8'h01) begin
            next_r.st = dof_pkg::ST_IDLE;
          end
        end else begin
          next_r.divCnt = r.divCnt + 8'h01;
        end
      end
      default: begin
        next_r.st = dof_pkg::ST_IDLE;
      end
    endcase

    // latch a new sample set; restarts the frame, late frame is cut short
    if (sampleValid) begin
      // a frame still running means the rate is too slow
      // placed after the register write so a same-cycle clear loses
      if (r.st == dof_pkg::ST_SHIFT) begin
        next_r.overrun = 1'b1;
      end
      // float parallel: 0000, exponent, mantissa; lower half zero
      if (isFloat) begin
        next_r.hold[0] = {4'h0, fIA, 16'h0000};
        next_r.hold[1] = {4'h0, fQA, 16'h0000};
        next_r.hold[2] = {4'h0, fIB, 16'h0000};
        next_r.hold[3] = {4'h0, fQB, 16'h0000};
        // mI eI eQ mQ, always packed
        strA    = {fIA[7:0], fIA[11:8], fQA[11:8], fQA[7:0], 40'h00_0000_0000};
        strB    = {fIB[7:0], fIB[11:8], fQB[11:8], fQB[7:0], 40'h00_0000_0000};
        chanLen = {1'b0, dof_pkg::LEN_FLOAT};
      end else begin
        next_r.hold = fixW;
      end
      next_r.st       = dof_pkg::ST_SHIFT;
      next_r.divCnt   = 8'h00;
      // limitation: polarity and mux writes count from the next sample strobe
      next_r.clkPol   = r.ctrl[dof_pkg::CTRL_CLK_POL];
      next_r.stbPol   = r.ctrl[dof_pkg::CTRL_STB_POL];
      next_r.muxOne   = r.ctrl[dof_pkg::CTRL_MUX];
      // packed: one strobe per channel; unpacked: one per component
      if (isFloat || r.ctrl[dof_pkg::CTRL_PACKED]) begin
        next_r.wordLen = chanLen[6:0];
      end else begin
        next_r.wordLen = cLen;
      end
      next_r.wordLeft = next_r.wordLen;
      // shared line: channel B right behind channel A
      if (r.ctrl[dof_pkg::CTRL_MUX]) begin
        next_r.shA   = {strA, 64'h0} | ({strB, 64'h0} >> chanLen);
        next_r.shB   = 128'h0;
        next_r.total = {chanLen[6:0], 1'b0};
      end else begin
        next_r.shA   = {strA, 64'h0};
        next_r.shB   = {strB, 64'h0};
        next_r.total = chanLen;
      end
      next_r.bitsLeft = next_r.total;
    end

    // ready for the first bit period of the period's first word
    next_r.ready = (next_r.st == dof_pkg::ST_SHIFT) && (next_r.bitsLeft == next_r.total);

    // clock high in the first half of each bit, inverted by polarity
    if (next_r.st == dof_pkg::ST_SHIFT) begin
      next_r.sck = ({1'b0, next_r.divCnt} < halfPer) ^ next_r.clkPol;
      // strobe on the first bit of each word, MSB first
      next_r.fs  = (next_r.wordLeft == next_r.wordLen) ^ next_r.stbPol;
      next_r.dA  = next_r.shA[127];
      // line B held low when shared
      next_r.dB  = next_r.muxOne ? 1'b0 : next_r.shB[127];
    end else begin
      next_r.sck = next_r.clkPol;
      next_r.fs  = next_r.stbPol;
      next_r.dA  = 1'b0;
      next_r.dB  = 1'b0;
    end
    // serial pins driven only when enabled
    next_r.sckOe = r.ctrl[dof_pkg::CTRL_SER_EN];

    // pin synchronisers, change taken once stages two and three agree
    // stage one feeds stage two only, so a metastable value never fans out
    next_r.selS1 = segmentSelect;
    next_r.selS2 = r.selS1;
    next_r.selS3 = r.selS2;
    if (r.selS2 == r.selS3) begin
      next_r.selStable = r.selS3;
    end
    next_r.enS1 = parallelOutputEnable_n;
    next_r.enS2 = r.enS1;
    next_r.enS3 = r.enS2;
    if (r.enS2 == r.enS3) begin
      next_r.enStable_n = r.enS3;
    end

    // segment select: word by pair of bits, half by lowest bit
    word = r.hold[r.selStable[2:1]];
    next_r.pData = r.selStable[0] ? word[15:0] : word[31:16];
    // driven only while enable is low
    next_r.pOe = ~r.enStable_n;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r            <= '0;
      r.st         <= dof_pkg::ST_IDLE;
      r.ctrl       <= dof_pkg::CTRL_RESET;
      r.rate       <= dof_pkg::RATE_RESET;
      r.selS1      <= 3'h0;
      r.enS1       <= 1'b1;
      r.enS2       <= 1'b1;
      r.enS3       <= 1'b1;
      r.enStable_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // outputs straight from flops
  // the four serial enables share one flop so the pins switch together
  assign regRdData           = r.rdData;
  assign sampleReady         = r.ready;
  assign serialClock         = r.sck;
  assign serialClockOe       = r.sckOe;
  assign serialFrameStrobe   = r.fs;
  assign serialFrameStrobeOe = r.sckOe;
  assign serialDataLineA     = r.dA;
  assign serialDataLineAOe   = r.sckOe;
  assign serialDataLineB     = r.dB;
  assign serialDataLineBOe   = r.sckOe;
  assign parallelData        = r.pData;
  assign parallelOe          = r.pOe;

endmodule : dof_output_formatter

// ===== bench/dof_output_formatter_chk.sv
// checker on the formatter's top-level ports
// assumes control words change only while the serial engine rests
module dof_output_formatter_chk (
  input wire logic                       clk,
  input wire logic                       arst_n,
  input wire logic                       sampleValid,
  input wire logic [dof_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0]                regWrData,
  input wire logic                       regWr,
  input wire logic                       parallelOutputEnable_n,
  input wire logic                       sampleReady,
  input wire logic                       serialClock,
  input wire logic                       serialClockOe,
  input wire logic                       serialFrameStrobe,
  input wire logic                       serialFrameStrobeOe,
  input wire logic                       serialDataLineAOe,
  input wire logic                       serialDataLineB,
  input wire logic                       serialDataLineBOe,
  input wire logic                       parallelOe
);
  logic [7:0] ctrlS;
  logic [7:0] rateS;
  logic [8:0] hiCnt;
  // ==========================================================================
  // shadow registers, and length of the ready pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlS <= dof_pkg::CTRL_RESET;
      rateS <= dof_pkg::RATE_RESET;
      hiCnt <= 9'h000;
    end else begin
      if (regWr && regAddr == dof_pkg::OFS_CTRL) ctrlS <= regWrData[7:0];
      if (regWr && regAddr == dof_pkg::OFS_RATE) rateS <= regWrData[7:0];
      hiCnt <= sampleReady ? hiCnt + 9'h001 : 9'h000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // assertions
  // pins enabled together
  chk_oe_together: assert property (
    serialClockOe == serialFrameStrobeOe && serialClockOe == serialDataLineAOe
    && serialClockOe == serialDataLineBOe) else $error("serial enables differ");
  // enable moves only after a write
  chk_oe_hold: assert property (
    !$past(regWr) && !$past(regWr, 2) |-> $stable(serialClockOe))
    else $error("serial enable moved without a write");
  chk_pen_follow: assert property (
    $stable(parallelOutputEnable_n)[*8] |-> parallelOe != parallelOutputEnable_n)
    else $error("parallel drive does not follow enable pin");
  chk_ready_start: assert property (
    sampleValid |=> sampleReady) else $error("no ready after new sample");
  chk_strobe_first: assert property (
    sampleValid |=> serialFrameStrobe != $past(ctrlS[dof_pkg::CTRL_STB_POL]))
    else $error("strobe not active at frame start");
  // first half of a bit away from idle
  chk_launch_edge: assert property (
    sampleValid |=> serialClock != $past(ctrlS[dof_pkg::CTRL_CLK_POL]))
    else $error("bit clock wrong at launch");
  chk_ready_len: assert property (
    $fell(sampleReady) |-> hiCnt == {1'b0, rateS} + 9'h001)
    else $error("ready pulse length wrong");
  // shared line leaves line b low
  chk_lineb_low: assert property (
    ctrlS[dof_pkg::CTRL_MUX] |-> !serialDataLineB) else $error("line b not low");
  cover property ($fell(sampleReady));
  cover property (parallelOe);
  cover property (ctrlS[dof_pkg::CTRL_MUX] && sampleReady);
endmodule : dof_output_formatter_chk

bind dof_output_formatter dof_output_formatter_chk chk (.clk, .arst_n, .sampleValid,
  .regAddr, .regWrData, .regWr, .parallelOutputEnable_n, .sampleReady, .serialClock,
  .serialClockOe, .serialFrameStrobe, .serialFrameStrobeOe, .serialDataLineAOe,
  .serialDataLineB, .serialDataLineBOe, .parallelOe);

// ===== bench/dof_bb_rx.sv
// model of the baseband receiver on serial lines a and b
// assumes it samples the pins on clk, faster than the bit clock
module dof_bb_rx (
  input wire logic   clk,
  input wire logic   sck,
  input wire logic   sckOe,
  input wire logic   fs,
  input wire logic   fsOe,
  input wire logic   dA,
  input wire logic   dAOe,
  input wire logic   dB,
  input wire logic   dBOe,
  input wire logic   clkPol,
  input wire logic   stbPol,
  output logic [63:0] rxWord = 64'h0,
  output logic [63:0] rxWordB = 64'h0,
  output logic [15:0] rxStrobes = 16'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hS = 1'b0, hF = 1'b0, hD = 1'b0, sckP = 1'b0;
  logic hB = 1'b0;
  // released lines show the inverse of their last driven level
  wire logic wS = sckOe ? sck : !hS;
  wire logic wF = fsOe ? fs : !hF;
  wire logic wD = dAOe ? dA : !hD;
  wire logic wB = dBOe ? dB : !hB;
  // ==========================================================================
  // capture
  always @(posedge clk) begin
    if (sckOe) hS <= sck;
    if (fsOe) hF <= fs;
    if (dAOe) hD <= dA;
    if (dBOe) hB <= dB;
    sckP <= wS;
    // capture on return to idle level
    if (wS != sckP && wS == clkPol) begin
      rxWord <= {rxWord[62:0], wD};
      rxWordB <= {rxWordB[62:0], wB};
      if (wF ^ stbPol) rxStrobes <= rxStrobes + 16'h1;
    end
  end
endmodule : dof_bb_rx

// ===== bench/dof_output_formatter_tb_top.sv
// bench top: formatter, receiver model and scenarios
// assumes the checker binds itself to the formatter
module dof_output_formatter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, arst_n = 1'b0, sampleValid = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [31:0] sIA = 32'h0, sQA = 32'h0, sIB = 32'h0, sQB = 32'h0, regWrData = 32'h0;
  logic [3:0]  regAddr = 4'h0;
  logic [2:0]  segSel = 3'h0;
  logic        pen_n = 1'b1;
  logic [7:0]  cfg = 8'h00;
  logic [31:0] regRdData;
  logic [15:0] parallelData, rxStrobes;
  logic [63:0] rxWord, rxWordB;
  logic sampleReady, sck, sckOe, fs, fsOe, dA, dAOe, dB, dBOe, parallelOe;
  int mismatches = 0, checks_done = 0;
  always #50 clk = ~clk;
  dof_output_formatter uut (.clk(clk), .arst_n(arst_n), .sampleValid(sampleValid),
    .sampleIA(sIA), .sampleQA(sQA), .sampleIB(sIB), .sampleQB(sQB), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .segmentSelect(segSel), .parallelOutputEnable_n(pen_n), .sampleReady(sampleReady),
    .serialClock(sck), .serialClockOe(sckOe), .serialFrameStrobe(fs),
    .serialFrameStrobeOe(fsOe), .serialDataLineA(dA), .serialDataLineAOe(dAOe),
    .serialDataLineB(dB), .serialDataLineBOe(dBOe), .parallelData(parallelData),
    .parallelOe(parallelOe));
  dof_bb_rx rx (.clk(clk), .sck(sck), .sckOe(sckOe), .fs(fs), .fsOe(fsOe), .dA(dA),
    .dAOe(dAOe), .dB(dB), .dBOe(dBOe), .clkPol(cfg[1]), .stbPol(cfg[2]), .rxWord(rxWord),
    .rxWordB(rxWordB), .rxStrobes(rxStrobes));
  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask : rd
  // one frame, then compare what the receiver captured
  task automatic ser(input logic [7:0] c, input logic [7:0] r, input logic [127:0] s,
                     input int n, input logic [63:0] e, input logic [15:0] ns);
    logic [15:0] s0;
    logic [31:0] st;
    logic [63:0] m;
    int i;
    cfg <= c;
    wr(dof_pkg::OFS_CTRL, {24'h0, c});
    wr(dof_pkg::OFS_RATE, {24'h0, r});
    s0 = rxStrobes;
    @(posedge clk);
    {sIA, sQA, sIB, sQB} <= s;
    sampleValid <= 1'b1;
    @(posedge clk);
    sampleValid <= 1'b0;
    for (i = 0; i < 300; i++) begin
      rd(dof_pkg::OFS_STATUS, st);
      if (c[3]) chk(dB, 1'b0);
      if (st[0] === 1'b0) break;
    end
    if (i == 300) begin
      mismatches++;
      end_of_test();
    end
    repeat (4) @(posedge clk);
    m = (n == 64) ? 64'hFFFF_FFFF_FFFF_FFFF : (64'h1 << n) - 64'h1;
    chk(rxWord & m, e);
    chk(rxStrobes - s0, ns);
  endtask : ser
  task automatic par(input logic [2:0] sel, input logic [15:0] exp);
    @(posedge clk);
    segSel <= sel;
    repeat (6) @(posedge clk);
    #1 chk(parallelData, exp);
  endtask : par
  // ==========================================================================
  // scenarios
  task automatic s_reset;
    logic [31:0] d;
    rd(dof_pkg::OFS_CTRL, d);
    chk(d, 32'h0);
    rd(dof_pkg::OFS_RATE, d);
    chk(d, 32'h1);
    rd(4'hC, d);
    chk(d, 32'h0);
    chk({sckOe, fsOe, dAOe, dBOe, parallelOe}, 5'h0);
  endtask : s_reset
  // i word then q word, no gap
  task automatic s_unpacked;
    ser(8'h01, 8'h01, {32'hA512_3456, 32'h3C00_0000, 64'h0}, 16, 64'hA53C, 2);
  endtask : s_unpacked
  task automatic s_packed;
    ser(8'h37, 8'h01, {32'h1234_5678, 32'h8001_7FFF, 64'h0}, 32, 64'h1234_8001, 1);
    pen_n <= 1'b0;
    par(3'h0, 16'h1234);
    par(3'h1, 16'h0000);
    par(3'h2, 16'h8001);
    chk(parallelOe, 1'b1);
  endtask : s_packed
  task automatic s_shared;
    ser(8'h19, 8'h01, {32'h1100_0000, 32'h2200_0000, 32'h3300_0000, 32'h4400_0000},
        32, 64'h1122_3344, 2);
  endtask : s_shared
  task automatic s_float;
    ser(8'h81, 8'h01, {32'h4000_0000, 32'h2000_0000, 64'h0}, 24, 64'h40FE40, 1);
    par(3'h0, 16'h0F40);
    par(3'h1, 16'h0000);
  endtask : s_float
  // slower clock still inside the period
  task automatic s_slow;
    ser(8'h41, 8'h03, {32'h0012_3400, 32'h7654_3210, 64'h0}, 48, 64'h12_3476_5432, 2);
  endtask : s_slow
  task automatic s_trunc32;
    logic [127:0] v;
    v = 128'hDEAD_BEEF_0123_4567_89AB_CDEF_FEDC_BA98;
    ser(8'h71, 8'h01, v, 64, v[127:64], 1);
    chk(rxWordB, v[63:0]);
    for (int i = 0; i < 8; i++) par(i[2:0], v[127-16*i -: 16]);
    pen_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk(parallelOe, 1'b0);
  endtask : s_trunc32
  // second sample lands mid-frame after the first ready pulse: overrun, then cleared
  task automatic s_overrun;
    logic [31:0] d;
    repeat (2) begin
      @(posedge clk);
      sampleValid <= 1'b1;
      @(posedge clk);
      sampleValid <= 1'b0;
      repeat (3) @(posedge clk);
    end
    rd(dof_pkg::OFS_STATUS, d);
    chk(d[dof_pkg::STAT_OVERRUN], 1'b1);
    wr(dof_pkg::OFS_STATUS, 32'h0000_0001 << dof_pkg::STAT_OVERRUN);
    rd(dof_pkg::OFS_STATUS, d);
    chk(d[dof_pkg::STAT_OVERRUN], 1'b0);
  endtask : s_overrun
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    s_reset();
    s_unpacked();
    s_packed();
    s_shared();
    s_float();
    s_slow();
    s_trunc32();
    s_overrun();
    end_of_test();
  end
endmodule : dof_output_formatter_tb_top
